// *** rtl/art_pkg.sv ***
package art_pkg;

    // =====================================================================
    // register offsets
    localparam logic [7:0] ART_CLKCTL_ADDR = 8'h8E;
    localparam logic [7:0] ART_CTL_ADDR    = 8'hC8;
    localparam logic [7:0] ART_RLL_ADDR    = 8'hCA;
    localparam logic [7:0] ART_RLH_ADDR    = 8'hCB;
    localparam logic [7:0] ART_CNTL_ADDR   = 8'hCC;
    localparam logic [7:0] ART_CNTH_ADDR   = 8'hCD;
    localparam logic [7:0] ART_STAT_ADDR   = 8'hD0;
    localparam logic [7:0] ART_MASK_ADDR   = 8'hD1;

    // =====================================================================
    // field positions
    localparam int ART_CK_HSEL_BIT = 5;
    localparam int ART_CK_LSEL_BIT = 4;
    localparam int ART_EV_HIGH     = 0;
    localparam int ART_EV_LOW      = 1;

    // =====================================================================
    // reset values and counts
    localparam logic [7:0] ART_BYTE_RST  = 8'h00;
    localparam logic [1:0] ART_PAIR_RST  = 2'h0;
    localparam logic [7:0] ART_BYTE_MAX  = 8'hFF;
    localparam int         ART_DIV_SYS   = 12;
    localparam int         ART_DIV_EXT   = 8;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_overflow_irq_enable;
        logic unused4;
        logic split_mode_select;
        logic run_control;
        logic unused1;
        logic external_clock_select;
    } art_ctl_s;

    localparam art_ctl_s ART_CTL_RST = '0;

endpackage

// *** rtl/art_prescale.sv ***
`timescale 1ns/1ps
`default_nettype none
module art_prescale
    import art_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_ext_clk,
    output logic      o_div12_tick,
    output logic      o_ext8_tick
);

    // =====================================================================
    // system clock divided by twelve
    logic [3:0] div12_cnt_ff;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div12_cnt_ff <= 4'h0;
            o_div12_tick <= 1'b0;
        end else begin
            o_div12_tick <= (div12_cnt_ff == 4'(ART_DIV_SYS - 1));
            if (div12_cnt_ff == 4'(ART_DIV_SYS - 1)) begin
                div12_cnt_ff <= 4'h0;
            end else begin
                div12_cnt_ff <= div12_cnt_ff + 4'h1;
            end
        end
    end

    // =====================================================================
    // external oscillator: two-stage sync, then edge count by eight
    // external must stay below half the system rate or edges are lost
    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;
    logic [2:0] ext_cnt_ff;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= i_ext_clk;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // one tick per eight rising edges of the synchronised clock
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ext_cnt_ff  <= 3'h0;
            o_ext8_tick <= 1'b0;
        end else begin
            o_ext8_tick <= 1'b0;
            if (sync2_ff && !sync3_ff) begin
                ext_cnt_ff  <= ext_cnt_ff + 3'h1;
                o_ext8_tick <= (ext_cnt_ff == 3'(ART_DIV_EXT - 1));
            end
        end
    end

endmodule
`default_nettype wire

// *** rtl/art_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module art_timer
    import art_pkg::*;
(
    input  wire logic       I_CLOCK,
    input  wire logic       I_NRST,
    input  wire logic       I_EXT_CLK,
    input  wire logic [7:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic      [7:0] O_RDATA,
    output logic            O_IRQ
);

    // =====================================================================
    // state
    art_ctl_s   ctl_ff;
    logic [1:0] ck_sel_ff;      // [1] high half, [0] low half
    logic [7:0] reload_low_byte_ff;
    logic [7:0] reload_high_byte_ff;
    logic [7:0] count_low_byte_ff;
    logic [7:0] count_high_byte_ff;
    logic [1:0] stat_ff;
    logic [1:0] mask_ff;
    logic       div12_tick;
    logic       ext8_tick;

    // =====================================================================
    // prescalers
    art_prescale art_prescale_i (
        .i_clk        (I_CLOCK),
        .i_nrst       (I_NRST),
        .i_ext_clk    (I_EXT_CLK),
        .o_div12_tick (div12_tick),
        .o_ext8_tick  (ext8_tick)
    );

    // =====================================================================
    // write decode
    logic wr_ctl;
    logic wr_ck;
    logic wr_rll;
    logic wr_rlh;
    logic wr_cl;
    logic wr_ch;
    logic wr_st;
    logic wr_mk;
    assign wr_ctl = I_WR && (I_ADDR == ART_CTL_ADDR);
    assign wr_ck  = I_WR && (I_ADDR == ART_CLKCTL_ADDR);
    assign wr_rll = I_WR && (I_ADDR == ART_RLL_ADDR);
    assign wr_rlh = I_WR && (I_ADDR == ART_RLH_ADDR);
    assign wr_cl  = I_WR && (I_ADDR == ART_CNTL_ADDR);
    assign wr_ch  = I_WR && (I_ADDR == ART_CNTH_ADDR);
    assign wr_st  = I_WR && (I_ADDR == ART_STAT_ADDR);
    assign wr_mk  = I_WR && (I_ADDR == ART_MASK_ADDR);

    // =====================================================================
    // count clock choice per half
    logic ext_pick;
    logic tick_h;
    logic tick_l;
    assign ext_pick = ctl_ff.external_clock_select ? ext8_tick : div12_tick;
    assign tick_h   = ck_sel_ff[1] ? 1'b1 : ext_pick;
    assign tick_l   = ck_sel_ff[0] ? 1'b1 : ext_pick;

    // =====================================================================
    // count enables and wrap events
    logic split;
    logic inc16;
    logic wrap16;
    logic low_max;
    logic high_max;
    logic high_evt;
    logic low_evt;
    assign split    = ctl_ff.split_mode_select;
    assign low_max  = (count_low_byte_ff == ART_BYTE_MAX);
    assign high_max = (count_high_byte_ff == ART_BYTE_MAX);
    assign inc16    = !split && ctl_ff.run_control && tick_h;
    assign wrap16   = inc16 && low_max && high_max;
    assign high_evt = split ? (ctl_ff.run_control && tick_h && high_max) : wrap16;
    assign low_evt  = split ? (tick_l && low_max) : (inc16 && low_max);

    // =====================================================================
    // low byte: always counts in split mode
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            count_low_byte_ff <= ART_BYTE_RST;
        end else if (wr_cl) begin
            count_low_byte_ff <= I_WDATA;
        end else if (split) begin
            if (tick_l) begin
                count_low_byte_ff <= low_max ? reload_low_byte_ff
                                             : count_low_byte_ff + 8'h01;
            end
        end else if (inc16) begin
            count_low_byte_ff <= wrap16 ? reload_low_byte_ff
                                        : count_low_byte_ff + 8'h01;
        end
    end

    // =====================================================================
    // high byte: run bit gates it in both modes
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            count_high_byte_ff <= ART_BYTE_RST;
        end else if (wr_ch) begin
            count_high_byte_ff <= I_WDATA;
        end else if (split) begin
            if (ctl_ff.run_control && tick_h) begin
                count_high_byte_ff <= high_max ? reload_high_byte_ff
                                               : count_high_byte_ff + 8'h01;
            end
        end else if (wrap16) begin
            count_high_byte_ff <= reload_high_byte_ff;
        end else if (inc16 && low_max) begin
            count_high_byte_ff <= count_high_byte_ff + 8'h01;
        end
    end

    // =====================================================================
    // control register; a hardware set beats a software clear
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            ctl_ff <= ART_CTL_RST;
        end else begin
            if (wr_ctl) begin
                ctl_ff.low_overflow_irq_enable <= I_WDATA[5];
                ctl_ff.split_mode_select       <= I_WDATA[3];
                ctl_ff.run_control             <= I_WDATA[2];
                ctl_ff.external_clock_select   <= I_WDATA[0];
            end
            // flags only leave by software write
            ctl_ff.high_overflow_flag <= (wr_ctl ? I_WDATA[7] : ctl_ff.high_overflow_flag)
                                         | high_evt;
            ctl_ff.low_overflow_flag  <= (wr_ctl ? I_WDATA[6] : ctl_ff.low_overflow_flag)
                                         | low_evt;
            ctl_ff.unused4 <= 1'b0;
            ctl_ff.unused1 <= 1'b0;
        end
    end

    // =====================================================================
    // reload bytes and clock selects
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            reload_low_byte_ff  <= ART_BYTE_RST;
            reload_high_byte_ff <= ART_BYTE_RST;
            ck_sel_ff           <= ART_PAIR_RST;
        end else begin
            if (wr_rll) begin
                reload_low_byte_ff <= I_WDATA;
            end
            if (wr_rlh) begin
                reload_high_byte_ff <= I_WDATA;
            end
            if (wr_ck) begin
                ck_sel_ff <= {I_WDATA[ART_CK_HSEL_BIT], I_WDATA[ART_CK_LSEL_BIT]};
            end
        end
    end

    // =====================================================================
    // interrupt status (write one to clear, set wins) and mask
    // low events only reach status while the low enable is set
    logic [1:0] evt;
    assign evt[ART_EV_HIGH] = high_evt;
    assign evt[ART_EV_LOW]  = low_evt && ctl_ff.low_overflow_irq_enable;
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            stat_ff <= ART_PAIR_RST;
            mask_ff <= ART_PAIR_RST;
        end else begin
            stat_ff <= (stat_ff & ~(wr_st ? I_WDATA[1:0] : 2'h0)) | evt;
            if (wr_mk) begin
                mask_ff <= I_WDATA[1:0];
            end
        end
    end

    // registered level interrupt; mask acts as the timer interrupt enable
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |(stat_ff & mask_ff);
        end
    end

    // =====================================================================
    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_RDATA <= ART_BYTE_RST;
        end else if (I_RD) begin
            case (I_ADDR)
                ART_CTL_ADDR:   O_RDATA <= ctl_ff;
                ART_CLKCTL_ADDR: O_RDATA <= {2'h0, ck_sel_ff, 4'h0};
                ART_RLL_ADDR:   O_RDATA <= reload_low_byte_ff;
                ART_RLH_ADDR:   O_RDATA <= reload_high_byte_ff;
                ART_CNTL_ADDR:  O_RDATA <= count_low_byte_ff;
                ART_CNTH_ADDR:  O_RDATA <= count_high_byte_ff;
                ART_STAT_ADDR:  O_RDATA <= {6'h00, stat_ff};
                ART_MASK_ADDR:  O_RDATA <= {6'h00, mask_ff};
                default:        O_RDATA <= ART_BYTE_RST;
            endcase
        end else begin
            O_RDATA <= ART_BYTE_RST;
        end
    end

    // =====================================================================
    // assertions
    sequence s_full_wrap;
        wrap16 && !wr_cl && !wr_ch && !wr_ctl;
    endsequence

    sequence s_low_wrap16;
        inc16 && low_max && !high_max && ctl_ff.low_overflow_irq_enable
            && mask_ff[ART_EV_LOW] && !wr_st && !wr_mk && !wr_ctl;
    endsequence

    a_wrap_reload: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        s_full_wrap |=> {count_high_byte_ff, count_low_byte_ff}
                        == $past({reload_high_byte_ff, reload_low_byte_ff}))
        else $error("16-bit wrap did not load reload value");

    a_wrap_flag: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        s_full_wrap |=> ctl_ff.high_overflow_flag && stat_ff[ART_EV_HIGH])
        else $error("16-bit wrap did not set high flag");

    a_irq_full: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        (s_full_wrap ##0 (mask_ff[ART_EV_HIGH] && !wr_mk && !wr_st)) |-> ##2 O_IRQ)
        else $error("full wrap did not raise interrupt");

    a_irq_low: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        s_low_wrap16 |-> ##2 O_IRQ)
        else $error("low byte wrap did not raise interrupt");

    a_low_free: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        (split && !ctl_ff.run_control && tick_l && !low_max && !wr_cl && !wr_ctl)
        |=> count_low_byte_ff == $past(count_low_byte_ff) + 8'h01)
        else $error("low counter stalled in split mode");

    a_high_hold: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        (split && !ctl_ff.run_control && !wr_ch) |=> $stable(count_high_byte_ff))
        else $error("stopped high counter moved");

    a_split_low: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        (split && tick_l && low_max && !wr_cl && !wr_ctl)
        |=> count_low_byte_ff == $past(reload_low_byte_ff) && ctl_ff.low_overflow_flag)
        else $error("split low wrap did not reload or flag");

    a_flag_sticky: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        (ctl_ff.high_overflow_flag && !wr_ctl) |=> ctl_ff.high_overflow_flag)
        else $error("high flag cleared without a write");

    a_ctl_unused: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        (I_RD && I_ADDR == ART_CTL_ADDR) |=> (O_RDATA[4] == 1'b0) && (O_RDATA[1] == 1'b0))
        else $error("unused control bits read nonzero");

    a_sys_select: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        (split && ck_sel_ff[0] && !low_max && !wr_cl && !wr_ctl)
        |=> count_low_byte_ff == $past(count_low_byte_ff) + 8'h01)
        else $error("system clock select did not count every cycle");

    sequence s_split_high_wrap;
        split && ctl_ff.run_control && tick_h && high_max && !wr_ch && !wr_ctl;
    endsequence

    sequence s_split_low_irq;
        split && tick_l && low_max && ctl_ff.low_overflow_irq_enable
            && mask_ff[ART_EV_LOW] && !wr_st && !wr_mk && !wr_ctl;
    endsequence

    a_split_high: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        s_split_high_wrap |=> count_high_byte_ff == $past(reload_high_byte_ff)
                              && ctl_ff.high_overflow_flag)
        else $error("split high wrap did not reload or flag");

    a_irq_split: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        s_split_low_irq |-> ##2 O_IRQ)
        else $error("split low wrap did not raise interrupt");

    a_low_flag16: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        (inc16 && low_max && !wr_ctl) |=> ctl_ff.low_overflow_flag)
        else $error("16-bit low byte wrap did not set low flag");

    // low wraps must stay out of status while the low enable is clear
    a_stat_gate: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        (!ctl_ff.low_overflow_irq_enable && !stat_ff[ART_EV_LOW]) |=> !stat_ff[ART_EV_LOW])
        else $error("low status set while low enable clear");

    a_run_stop16: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        (!split && !ctl_ff.run_control && !wr_cl && !wr_ch)
        |=> $stable({count_high_byte_ff, count_low_byte_ff}))
        else $error("stopped 16-bit counter moved");

    a_count_write: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        wr_cl |=> count_low_byte_ff == $past(I_WDATA))
        else $error("low count byte write did not land");

endmodule
`default_nettype wire

// *** tb/art_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module art_timer_tb
    import art_pkg::*;
;
    // =====================================================================
    // signals
    typedef struct packed {
        logic [7:0] exp;
        logic [7:0] msk;
    } art_note_s;

    logic       I_CLOCK   = 1'b0;
    logic       I_NRST    = 1'b0;
    logic       I_EXT_CLK = 1'b0;
    logic [7:0] I_ADDR    = 8'h00;
    logic [7:0] I_WDATA   = 8'h00;
    logic       I_WR      = 1'b0;
    logic       I_RD      = 1'b0;
    logic [7:0] O_RDATA;
    logic       O_IRQ;
    art_note_s  note_q[$];
    art_note_s  cur;
    int         fails     = 0;
    int         cmp_count = 0;
    logic       rd_d      = 1'b0;
    logic [2:0] ext_cnt   = 3'h0;
    logic [7:0] rl;
    logic [7:0] rh;
    logic [7:0] rst_addr [9] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h8E, 8'hD0, 8'hD1, 8'h00};

    art_timer art_timer_i (
        .I_CLOCK   (I_CLOCK),
        .I_NRST    (I_NRST),
        .I_EXT_CLK (I_EXT_CLK),
        .I_ADDR    (I_ADDR),
        .I_WDATA   (I_WDATA),
        .I_WR      (I_WR),
        .I_RD      (I_RD),
        .O_RDATA   (O_RDATA),
        .O_IRQ     (O_IRQ)
    );

    // 50 ns system clock
    always #25 I_CLOCK = ~I_CLOCK;

    // free-running oscillator, 8 cycles a period, well under a quarter rate
    always @(posedge I_CLOCK) begin
        ext_cnt   <= ext_cnt + 3'h1;
        I_EXT_CLK <= ext_cnt[2];
    end

    // =====================================================================
    // comparison and verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // read data stands only in the cycle after the strobe: sample it there
    always @(posedge I_CLOCK) begin
        rd_d <= I_RD;
        if (rd_d) begin
            if (note_q.size() == 0) begin
                fails++;
                $display("[FAIL] %0t read data with no note", $time);
            end else begin
                cur = note_q.pop_front();
                check(O_RDATA & cur.msk, cur.exp);
            end
        end else if (I_NRST) begin
            // outside the cycle after a read the data bus must rest at zero
            check(O_RDATA, 8'h00);
        end
    end

    // =====================================================================
    // bus tasks; one idle cycle after each strobe so no signal is set twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        I_ADDR  <= a;
        I_WDATA <= d;
        I_WR    <= 1'b1;
        @(posedge I_CLOCK);
        I_WR <= 1'b0;
        @(posedge I_CLOCK);
    endtask

    // counts are only known to a tick or so, hence the mask
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hFF);
        note_q.push_back('{exp: e & m, msk: m});
        I_ADDR <= a;
        I_RD   <= 1'b1;
        @(posedge I_CLOCK);
        I_RD <= 1'b0;
        @(posedge I_CLOCK);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge I_CLOCK);
    endtask

    // irq is looked at mid-cycle, away from the edge
    task automatic irq(input logic e);
        @(negedge I_CLOCK);
        check({7'h00, O_IRQ}, {7'h00, e});
        @(posedge I_CLOCK);
    endtask

    // hang guard
    initial begin
        wait_cyc(100000);
        fails++;
        results();
    end

    // =====================================================================
    // main sequence
    initial begin
        void'($urandom(11920));
        wait_cyc(16);
        I_NRST <= 1'b1;
        @(posedge I_CLOCK);
        // reset values, unmapped place included
        foreach (rst_addr[k]) rd(rst_addr[k], 8'h00);
        irq(1'b0);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h00);
        wr(8'hC8, 8'hFF);
        rd(8'hC8, 8'hED);
        wr(8'hC8, 8'h00);
        rd(8'hC8, 8'h00);
        // 16-bit wrap on system clock, reload and high flag
        rl = 8'($urandom) & 8'h3F;
        rh = 8'h10 + (8'($urandom) & 8'h7F);
        wr(8'h8E, 8'h20);
        wr(8'hCA, rl);
        wr(8'hCB, rh);
        wr(8'hCC, 8'hFD);
        wr(8'hCD, 8'hFF);
        wr(8'hD1, 8'h01);
        wr(8'hC8, 8'h04);
        wait_cyc(20);
        rd(8'hCD, rh);
        rd(8'hC8, 8'hC4);
        rd(8'hD0, 8'h01);
        irq(1'b1);
        wait_cyc(40);
        rd(8'hC8, 8'hC4);
        wr(8'hD0, 8'h01);
        wait_cyc(3);
        irq(1'b0);
        wr(8'hC8, 8'h00);
        rd(8'hC8, 8'h00);
        // 16-bit low byte wrap with low interrupt enable
        wr(8'hCC, 8'hFD);
        wr(8'hCD, 8'h00);
        wr(8'hD1, 8'h03);
        wr(8'hC8, 8'h24);
        wait_cyc(15);
        rd(8'hD0, 8'h02);
        rd(8'hC8, 8'h64);
        rd(8'hCD, 8'h01);
        irq(1'b1);
        wr(8'hC8, 8'h00);
        wr(8'hD0, 8'h03);
        // split: low always runs, high waits for run
        rl = 8'($urandom) & 8'h60;
        rh = 8'($urandom) & 8'hC0;
        wr(8'h8E, 8'h30);
        wr(8'hCA, rl);
        wr(8'hCB, rh);
        wr(8'hCC, 8'hFD);
        wr(8'hCD, 8'hFD);
        wr(8'hD1, 8'h00);
        wr(8'hC8, 8'h08);
        wait_cyc(12);
        rd(8'hCC, rl, 8'hE0);
        rd(8'hCD, 8'hFD);
        rd(8'hC8, 8'h48);
        rd(8'hD0, 8'h00);
        wr(8'hD1, 8'h02);
        wr(8'hC8, 8'h2C);
        wait_cyc(6);
        rd(8'hCD, rh, 8'hE0);
        rd(8'hC8, 8'hAC);
        rd(8'hD0, 8'h01);
        irq(1'b0);
        wait_cyc(260);
        rd(8'hD0, 8'h03);
        rd(8'hC8, 8'hC0, 8'hC0);
        irq(1'b1);
        wr(8'hC8, 8'h00);
        wr(8'hD0, 8'h03);
        // 16-bit on /12 although the low half asks for system clock
        wr(8'h8E, 8'h10);
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h04);
        wait_cyc(432);
        wr(8'hC8, 8'h00);
        rd(8'hCC, 8'h20, 8'hF8);
        // external oscillator divided by 8
        wr(8'h8E, 8'h00);
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h05);
        wait_cyc(1280);
        wr(8'hC8, 8'h00);
        rd(8'hCC, 8'h10, 8'hF8);
        // split halves on different clocks: high fast, low /12
        wr(8'h8E, 8'h20);
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h0C);
        wait_cyc(432);
        rd(8'hC8, 8'h80, 8'h80);
        wr(8'hC8, 8'h00);
        rd(8'hCC, 8'h20, 8'hF8);
        wait_cyc(2);
        if (note_q.size() != 0) begin
            fails++;
            $display("[FAIL] %0t reads left unchecked", $time);
        end
        results();
    end
endmodule
`default_nettype wire
